// [fdo_map.vh]
// Register offsets, field positions and reset values of the drive control outputs
`ifndef FDO_MAP_VH
`define FDO_MAP_VH

// ==========================================
// Register byte offsets
`define FDO_OFS_DIGOUT   8'h00
`define FDO_OFS_DSR      8'h04
`define FDO_OFS_CFGCTL   8'h08
`define FDO_OFS_FUNCEN   8'h0c
`define FDO_OFS_FUNCCTL  8'h10
`define FDO_OFS_MODE     8'h14
`define FDO_OFS_STA      8'h18

// ==========================================
// Field positions
`define FDO_DIGOUT_SEL_LO   0
`define FDO_DIGOUT_SEL_HI   1
`define FDO_DIGOUT_MOTOR_LO 4
`define FDO_DIGOUT_MOTOR_HI 7
`define FDO_RATE_LO      0
`define FDO_RATE_HI      1
`define FDO_FUNCEN_ENC   4
`define FDO_FUNCCTL_SWAP 4
`define FDO_MODE_DEN_LO  0
`define FDO_MODE_DEN_HI  1
`define FDO_MODE_PPORT   2
`define FDO_MODE_ROUTE   3
`define FDO_MODE_ALT     4
`define FDO_STA_DRIVE2   7

// ==========================================
// Encodings
`define FDO_RATE_300K    2'h1
`define FDO_RATE_250K    2'h2
`define FDO_DEN_HIGH     2'h1
`define FDO_DEN_LOW      2'h2

// ==========================================
// Reset values
`define FDO_RST_DIGOUT   8'h00
`define FDO_RST_RATE     2'h0
`define FDO_RST_BYTE     8'h00
`define FDO_RST_WORD     32'h0000_0000

`endif

// [fdo_out_reg.v]
// Output register with a constant reset value, one per group of drive pins
module fdo_out_reg #(
    parameter       W   = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input  wire         clk,
    input  wire         arst_n,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    // ==========================================
    // Storage
    // Reset takes only the constant, never a port value
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

endmodule // fdo_out_reg

// [fdo_top.v]
// Floppy drive control outputs: density, direction, drive selects, rate pins
//
// The implementer's own choices: register access over APB and the register addresses.
`include "fdo_map.vh"

module fdo_top (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // Controller core status
    input  wire        seek_active,
    input  wire        seek_inward,
    input  wire        rw_active,
    // Drive inputs
    input  wire        drive_type_ident,
    input  wire        second_drive_present,
    // Drive outputs
    output wire        density_select_out,
    output wire        step_direction_out,
    output wire [1:0]  drive_select_out_n,
    output wire [3:0]  motor_enable_out,
    output wire [1:0]  rate_indicator_out,
    // Parallel port copies
    output wire        pp_floppy_active,
    output wire        pp_density_select_out,
    output wire        pp_step_direction_out,
    output wire        pp_drive_select_out_n
);

    // ==========================================
    // Register state
    reg  [7:0] digital_output_reg;
    reg  [1:0] data_rate_reg;
    reg  [1:0] config_control_reg;
    reg        rate_from_cfg;
    reg  [7:0] function_enable_reg;
    reg  [7:0] function_control_reg;
    reg  [7:0] mode_reg;

    wire       access;
    wire       wr_now;
    wire       rd_now;
    wire       mapped;
    reg  [31:0] next_prdata;

    // ==========================================
    // APB handshake
    // One wait state so that pready and prdata both come from flops
    assign access = psel & penable & ~pready;
    assign wr_now = access & pwrite;
    assign rd_now = access & ~pwrite;
    assign mapped = (paddr == `FDO_OFS_DIGOUT)  || (paddr == `FDO_OFS_DSR) ||
                    (paddr == `FDO_OFS_CFGCTL)  || (paddr == `FDO_OFS_FUNCEN) ||
                    (paddr == `FDO_OFS_FUNCCTL) || (paddr == `FDO_OFS_MODE) ||
                    (paddr == `FDO_OFS_STA);

    // Answer flops
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `FDO_RST_WORD;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= rd_now ? next_prdata : `FDO_RST_WORD;
        end
    end

    // ==========================================
    // Register writes, taken on the edge where pready is sampled high
    wire wr_take;
    assign wr_take = psel & penable & pready & pwrite;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            digital_output_reg   <= `FDO_RST_DIGOUT;
            data_rate_reg        <= `FDO_RST_RATE;
            config_control_reg   <= `FDO_RST_RATE;
            rate_from_cfg        <= 1'b0;
            function_enable_reg  <= `FDO_RST_BYTE;
            function_control_reg <= `FDO_RST_BYTE;
            mode_reg             <= `FDO_RST_BYTE;
        end else if (wr_take) begin
            case (paddr)
                `FDO_OFS_DIGOUT: begin
                    digital_output_reg <= pwdata[7:0];
                end
                `FDO_OFS_DSR: begin
                    data_rate_reg <= pwdata[`FDO_RATE_HI:`FDO_RATE_LO];
                    rate_from_cfg <= 1'b0;
                end
                `FDO_OFS_CFGCTL: begin
                    config_control_reg <= pwdata[`FDO_RATE_HI:`FDO_RATE_LO];
                    rate_from_cfg      <= 1'b1;
                end
                `FDO_OFS_FUNCEN: begin
                    function_enable_reg <= pwdata[7:0];
                end
                `FDO_OFS_FUNCCTL: begin
                    function_control_reg <= pwdata[7:0];
                end
                `FDO_OFS_MODE: begin
                    mode_reg <= pwdata[7:0];
                end
                default: begin
                    mode_reg <= mode_reg;
                end
            endcase
        end
    end

    // ==========================================
    // Rate and density
    wire [1:0] cur_rate;
    wire [1:0] den_setting;
    reg        high_density;
    wire       next_density;

    // Last written rate register wins
    assign cur_rate    = rate_from_cfg ? config_control_reg : data_rate_reg;
    assign den_setting = mode_reg[`FDO_MODE_DEN_HI:`FDO_MODE_DEN_LO];

    // Forced setting overrides the rate-based choice
    always @* begin
        case (den_setting)
            `FDO_DEN_HIGH: high_density = 1'b1;
            `FDO_DEN_LOW:  high_density = 1'b0;
            default: high_density = (cur_rate != `FDO_RATE_300K) &&
                                    (cur_rate != `FDO_RATE_250K);
        endcase
    end

    // Polarity flips with drive type
    assign next_density = drive_type_ident ? high_density : ~high_density;

    // ==========================================
    // Head direction
    // Reads and writes override, so a stale seek flag cannot leak out
    wire next_direction;
    assign next_direction = seek_active & seek_inward & ~rw_active;

    // ==========================================
    // Drive selects
    wire [1:0] sel;
    wire [3:0] motor;
    wire       swap;
    wire       encoded;
    reg  [1:0] next_select_n;
    wire       log0_n;
    wire       log1_n;

    assign sel     = digital_output_reg[`FDO_DIGOUT_SEL_HI:`FDO_DIGOUT_SEL_LO];
    assign motor   = digital_output_reg[`FDO_DIGOUT_MOTOR_HI:`FDO_DIGOUT_MOTOR_LO];
    assign swap    = function_control_reg[`FDO_FUNCCTL_SWAP];
    assign encoded = function_enable_reg[`FDO_FUNCEN_ENC];

    // Logical drive 0 and 1 selects, gated by their motor bits
    assign log0_n = ~((sel == 2'h0) & motor[0]);
    assign log1_n = ~((sel == 2'h1) & motor[1]);

    // Encoded form carries the drive number only while its motor runs;
    // all-high is then the idle pattern, so drive 0 shares it with idle
    always @* begin
        if (encoded) begin
            next_select_n = motor[sel] ? ~sel : 2'h3;
        end else if (swap) begin
            next_select_n = {log0_n, log1_n};
        end else begin
            next_select_n = {log1_n, log0_n};
        end
    end

    // ==========================================
    // Parallel port copies
    wire pp_on;
    wire next_pp_den;
    wire next_pp_dir;
    wire next_pp_sel_n;

    assign pp_on         = mode_reg[`FDO_MODE_PPORT] & ~mode_reg[`FDO_MODE_ROUTE];
    assign next_pp_den   = pp_on ? next_density : 1'b0;
    assign next_pp_dir   = pp_on ? next_direction : 1'b0;
    assign next_pp_sel_n = pp_on ? (swap ? log0_n : log1_n) : 1'b1;

    // ==========================================
    // Read mux
    always @* begin
        next_prdata = `FDO_RST_WORD;
        case (paddr)
            `FDO_OFS_DIGOUT:  next_prdata[7:0] = digital_output_reg;
            `FDO_OFS_DSR:     next_prdata[1:0] = data_rate_reg;
            `FDO_OFS_CFGCTL:  next_prdata[1:0] = config_control_reg;
            `FDO_OFS_FUNCEN:  next_prdata[7:0] = function_enable_reg;
            `FDO_OFS_FUNCCTL: next_prdata[7:0] = function_control_reg;
            `FDO_OFS_MODE: next_prdata[7:0] = mode_reg;
            `FDO_OFS_STA: begin
                // Drive present only shown in the alternate mode
                next_prdata[`FDO_STA_DRIVE2] = mode_reg[`FDO_MODE_ALT] &
                                             second_drive_present;
                next_prdata[3:0] = {step_direction_out, density_select_out,
                                    drive_select_out_n};
            end
            default: next_prdata = `FDO_RST_WORD;
        endcase
    end

    // ==========================================
    // Output flops: selects idle high, direction low from reset
    fdo_out_reg #(
        .W   (10),
        .RST (10'h003)
    ) u_drive_reg (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({next_density, next_direction, motor, cur_rate, next_select_n}),
        .q      ({density_select_out, step_direction_out, motor_enable_out,
                  rate_indicator_out, drive_select_out_n})
    );

    // Parallel copies idle inactive while the port is not routed
    fdo_out_reg #(
        .W   (4),
        .RST (4'h1)
    ) u_pp_reg (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({pp_on, next_pp_den, next_pp_dir, next_pp_sel_n}),
        .q      ({pp_floppy_active, pp_density_select_out, pp_step_direction_out,
                  pp_drive_select_out_n})
    );

endmodule // fdo_top

// [fdo_drives.sv]
// Behavioural drive cable: drive kind strap and second drive presence
module fdo_drives (
    // Clock and bench choice of drives
    input  logic       clk,
    input  logic [1:0] fit,
    // Drive outputs towards the controller
    output logic       drive_type_ident,
    output logic       second_drive_present
);
    // Straps move only just after an edge, never mid-cycle
    always @(posedge clk) {second_drive_present, drive_type_ident} <= fit;
endmodule // fdo_drives

// [fdo_top_properties.sv]
// Port-level assertions for the drive control outputs
`include "fdo_map.vh"
module fdo_chk (
    // Clock, reset and bus
    input logic       clk,
    input logic       arst_n,
    input logic       psel,
    input logic       penable,
    input logic       pwrite,
    input logic       pready,
    input logic [7:0] paddr,
    // Core and drive inputs
    input logic       seek_active,
    input logic       seek_inward,
    input logic       rw_active,
    input logic       drive_type_ident,
    // Drive outputs
    input logic       density_select_out,
    input logic       step_direction_out,
    input logic [1:0] drive_select_out_n,
    input logic [1:0] rate_indicator_out,
    input logic       pp_floppy_active,
    input logic       pp_density_select_out,
    input logic       pp_step_direction_out
);
    // ==========================================
    // Checks, one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Only a rate register write may move the rate pins
    wire rate_wr = psel && pwrite && (paddr == `FDO_OFS_DSR || paddr == `FDO_OFS_CFGCTL);
    // A write that lands at this edge; only such a write may also move density
    wire wr_land = psel && penable && pready && pwrite;
    AST_DIR_IN: assert property (
        seek_active && seek_inward && !rw_active |=> step_direction_out)
        else $error("direction low on inward seek");
    AST_DIR_OUT: assert property (
        seek_active && !seek_inward |=> !step_direction_out)
        else $error("direction high on outward seek");
    AST_DIR_RW: assert property (
        rw_active |=> !step_direction_out)
        else $error("direction high during transfer");
    AST_RST: assert property (
        $rose(arst_n) |-> !step_direction_out && drive_select_out_n == 2'b11
        ##1 drive_select_out_n == 2'b11)
        else $error("outputs active after reset");
    AST_SEL_SRC: assert property (
        $changed(drive_select_out_n) |-> $past(psel && pwrite, 2))
        else $error("selects moved without a write");
    AST_RATE_SRC: assert property (
        $changed(rate_indicator_out) |-> $past(rate_wr, 2))
        else $error("rate pins moved without rate write");
    AST_DENS_FLIP: assert property (
        $past(arst_n) && !$past(wr_land) && $changed(drive_type_ident)
        |=> $changed(density_select_out))
        else $error("density ignored drive type");
    AST_PP_DEN: assert property (
        pp_density_select_out == (pp_floppy_active && density_select_out))
        else $error("parallel density copy wrong");
    AST_PP_DIR: assert property (
        pp_floppy_active |-> pp_step_direction_out == step_direction_out)
        else $error("parallel direction copy wrong");
    // Main scenarios reached
    cover property (step_direction_out);
    cover property (drive_select_out_n == 2'b00);
    cover property (pp_floppy_active && pp_step_direction_out);
endmodule // fdo_chk

bind fdo_top fdo_chk fdo_chk_i (.clk, .arst_n, .psel, .penable, .pwrite, .pready, .paddr,
    .seek_active,
    .seek_inward, .rw_active, .drive_type_ident, .density_select_out, .step_direction_out,
    .drive_select_out_n, .rate_indicator_out, .pp_floppy_active, .pp_density_select_out,
    .pp_step_direction_out);

// [fdo_top_test.sv]
// Self-checking bench for the floppy drive control outputs
`include "fdo_map.vh"
module fdo_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, enc, sw;
    logic        seek_active, seek_inward, rw_active, drive_type_ident, second_drive_present;
    logic        density_select_out, step_direction_out, pp_floppy_active;
    logic        pp_density_select_out, pp_step_direction_out, pp_drive_select_out_n;
    logic [1:0]  drive_select_out_n, rate_indicator_out, fit, rt;
    logic [3:0]  motor_enable_out;
    logic [4:0]  md;
    logic [7:0]  paddr, dout;
    logic [31:0] pwdata, prdata, rng, r;
    logic [43:0] q[$];
    int          fails, samples_checked;
    wire  [9:0]  pins = {motor_enable_out, rate_indicator_out, pp_floppy_active,
                         pp_density_select_out, pp_step_direction_out, pp_drive_select_out_n};
    fdo_top fdo_top_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .seek_active, .seek_inward, .rw_active, .drive_type_ident,
        .second_drive_present, .density_select_out, .step_direction_out, .drive_select_out_n,
        .motor_enable_out, .rate_indicator_out, .pp_floppy_active, .pp_density_select_out,
        .pp_step_direction_out, .pp_drive_select_out_n);
    fdo_drives fdo_drives_i (.clk, .fit, .drive_type_ident, .second_drive_present);
    always #50 clk = ~clk;
    // Xorshift source, fixed start
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_pins(input logic [9:0] e, input logic [9:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // One APB transfer, held until pready is seen; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Status read; expected pins worked out from the bench's settings
    task automatic rd_st();
        logic hi, den, dir, pa, d0, d1;
        logic [1:0] s;
        hi = md[1:0] == `FDO_DEN_HIGH ||
             (md[1:0] != `FDO_DEN_LOW && rt != `FDO_RATE_300K && rt != `FDO_RATE_250K);
        den = ~(hi ^ fit[0]);
        dir = seek_active & seek_inward & ~rw_active;
        pa = md[2] & ~md[3];
        d0 = dout[1:0] == 2'h0 && dout[4];
        d1 = dout[1:0] == 2'h1 && dout[5];
        s = enc ? (dout[4 + dout[1:0]] ? ~dout[1:0] : 2'b11) : (sw ? ~{d0, d1} : ~{d1, d0});
        q.push_back({1'b1, dout[7:4], rt, pa, pa & den, pa & dir, ~pa | ~(sw ? d0 : d1), 1'b0,
                     24'h0, fit[1] & md[4], 3'h0, dir, den, s});
        bus(1'b0, `FDO_OFS_STA, 32'h0);
    endtask
    // Oldest note taken at each completed read
    always @(posedge clk) begin
        logic [43:0] e;
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
            e = q.pop_front();
            cmp_rd(e[32:0], {pslverr, prdata});
            if (e[43]) cmp_pins(e[42:33], pins);
        end
    end
    task automatic print_verdict();
        $display("checked %0d wrong %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence: reset state, unmapped read, sweep of all select, swap/encode and density-setting codes, second reset
    initial begin
        {clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {seek_active, seek_inward, rw_active, fit, rt, dout, md, enc, sw} = '0;
        rng = 32'h6655ed43;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_st();
        q.push_back(44'h1_0000_0000);
        bus(1'b0, 8'h1c, 32'h0);
        $display("reset and unmapped test done");
        for (int i = 0; i < 64; i++) begin
            r = xs();
            {seek_active, seek_inward, rw_active, fit} <= r[20:16];
            dout = {r[7:2], i[1:0]};
            {sw, enc} = i[3:2];
            md = {r[10:8], i[5:4]};
            rt = r[12:11];
            bus(1'b1, `FDO_OFS_FUNCEN, {27'h0, enc, 4'h0});
            bus(1'b1, `FDO_OFS_FUNCCTL, {r[31:24], 19'h0, sw, 4'h0});
            bus(1'b1, `FDO_OFS_MODE, {27'h0, md});
            bus(1'b1, r[13] ? `FDO_OFS_DSR : `FDO_OFS_CFGCTL, {30'h0, ~rt});
            bus(1'b1, r[13] ? `FDO_OFS_CFGCTL : `FDO_OFS_DSR, {30'h0, rt});
            bus(1'b1, `FDO_OFS_DIGOUT, {24'h0, dout});
            bus(1'b1, `FDO_OFS_STA, r);
            rd_st();
        end
        $display("register sweep test done");
        {seek_active, seek_inward, rw_active} <= 3'h0;
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        {rt, dout, md, enc, sw} = '0;
        @(posedge clk);
        rd_st();
        $display("second reset test done");
        if (q.size() != 0) fails++;
        print_verdict();
    end
    // Watchdog, far beyond the some 2100 cycles the run needs
    initial begin
        #1000000;
        fails++;
        print_verdict();
    end
endmodule // fdo_top_test
